// ---- hw/csas_clkdiv.sv ----
// conversion clock divider producing a one-cycle enable pulse
`timescale 1ns/10ps
`default_nettype none
module csas_clkdiv (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // control
  input  wire logic       run,
  input  wire logic [2:0] sel,
  // enable out
  output var  logic       tick
);
  logic [5:0] cnt_r;
  logic [5:0] limit;

  // divide code to terminal count, rc codes use the slowest rate
  always_comb begin
    unique case (sel)
      3'h0: limit = 6'h01;
      3'h1: limit = 6'h07;
      3'h2: limit = 6'h1f;
      3'h4: limit = 6'h03;
      3'h5: limit = 6'h0f;
      default: limit = 6'h3f;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 6'h00;
      tick  <= 1'b0;
    end else if (!run || cnt_r == limit) begin
      cnt_r <= 6'h00;
      tick  <= run;
    end else begin
      cnt_r <= cnt_r + 6'h01;
      tick  <= 1'b0;
    end
  end
endmodule : csas_clkdiv
`default_nettype wire

// ---- hw/csas_pkg.sv ----
// package: register map, field positions, reset values and timing of the sequencer
package csas_pkg;

  // register addresses, sensing bank
  localparam logic [11:0] ADDR_CTRL0 = 12'h711;
  localparam logic [11:0] ADDR_CTRL1 = 12'h712;
  localparam logic [11:0] ADDR_CTRL2 = 12'h713;
  localparam logic [11:0] ADDR_CTRL3 = 12'h714;
  localparam logic [11:0] ADDR_STAT  = 12'h715;
  localparam logic [11:0] ADDR_PRE   = 12'h716;
  localparam logic [11:0] ADDR_ACQ   = 12'h717;
  localparam logic [11:0] ADDR_GRD   = 12'h718;
  localparam logic [11:0] ADDR_CAP   = 12'h719;
  localparam logic [11:0] ADDR_R0L   = 12'h71a;
  localparam logic [11:0] ADDR_R0H   = 12'h71b;
  localparam logic [11:0] ADDR_R1L   = 12'h71c;
  localparam logic [11:0] ADDR_R1H   = 12'h71d;
  // register addresses, low bank aliases
  localparam logic [11:0] ADDR_A_R0L   = 12'h09b;
  localparam logic [11:0] ADDR_A_R0H   = 12'h09c;
  localparam logic [11:0] ADDR_A_CTRL0 = 12'h09d;
  localparam logic [11:0] ADDR_A_CTRL1 = 12'h09e;
  localparam logic [11:0] ADDR_A_CTRL2 = 12'h09f;
  // interrupt flag register of our own
  localparam logic [11:0] ADDR_IRQ     = 12'h720;

  // control 0 fields
  localparam int CTRL0_ON  = 0;
  localparam int CTRL0_GO  = 1;
  localparam int CTRL0_CHS = 2;
  // control 3 fields
  localparam int CTRL3_DSEN  = 0;
  localparam int CTRL3_IPEN  = 1;
  localparam int CTRL3_OOEN  = 3;
  localparam int CTRL3_OEN   = 4;
  localparam int CTRL3_IPPOL = 6;
  localparam int CTRL3_EPPOL = 7;
  // guard control fields
  localparam int GRD_POL = 4;
  localparam int GRD_BOE = 6;
  localparam int GRD_AOE = 7;
  // control 1 result format bit
  localparam int CTRL1_FM = 7;

  // writable masks, unimplemented bits read as zero
  localparam logic [7:0] MASK_CTRL0 = 8'h7f;
  localparam logic [7:0] MASK_CTRL1 = 8'hf3;
  localparam logic [7:0] MASK_CTRL2 = 8'h70;
  localparam logic [7:0] MASK_CTRL3 = 8'hdb;
  localparam logic [7:0] MASK_COUNT = 8'h7f;
  localparam logic [7:0] MASK_CAP   = 8'h07;
  localparam logic [7:0] MASK_GRD   = 8'hd0;
  localparam logic [7:0] RST_BYTE   = 8'h00;

  // channel codes
  localparam logic [4:0] CHS_IN_LAST = 5'h04;
  localparam logic [4:0] CHS_VREFP   = 5'h1a;
  localparam logic [4:0] CHS_TEMP    = 5'h1d;
  localparam logic [4:0] CHS_FIXREF  = 5'h1f;

  // timing
  localparam logic [2:0] TRIG_TIMER   = 3'h3;
  localparam logic [1:0] DOUBLE_GAP   = 2'h2;
  localparam logic [4:0] CONV_CYCLES  = 5'h0b;
  localparam logic [3:0] RES_BITS     = 4'ha;

  // sequencer states
  typedef enum logic [5:0] {
    CSAS_IDLE = 6'h01,
    CSAS_PRE  = 6'h02,
    CSAS_ACQ  = 6'h04,
    CSAS_CONV = 6'h08,
    CSAS_GAP  = 6'h10,
    CSAS_DONE = 6'h20
  } csas_state_e;

endpackage : csas_pkg

// ---- hw/csas_top.sv ----
// capacitive sensing converter sequencer with dual-bank register file
`timescale 1ns/10ps
`default_nettype none
module csas_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [11:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // converter side
  input  wire logic        timer_trigger,
  input  wire logic        conv_bit,
  output logic             conv_sample,
  output logic             converter_enable,
  // analog switches
  output logic      [7:0]  channel_onehot,
  output logic      [2:0]  extra_cap_select,
  output logic             extra_cap_connect,
  output logic             hold_capacitor_connect,
  output logic             hold_precharge_level,
  output logic             hold_precharge_en,
  // selected channel pin override
  output logic             chan_pin_out,
  output logic             chan_pin_oe,
  // analog bus pin
  output logic             bus_pass_gate,
  output logic             analog_bus_pin_out,
  output logic             analog_bus_pin_oe,
  // guard outputs
  output logic             guard_a,
  output logic             guard_b,
  // status
  output logic             conversion_irq_flag
);
  csas_pkg::csas_state_e st_r, st_nxt;
  logic [7:0] ctrl0_r, ctrl1_r, ctrl2_r, ctrl3_r, pre_r, acq_r, grd_r, cap_r;
  logic [9:0] res0_r, res1_r, shift_r;
  logic [6:0] cnt_r;
  logic [4:0] bits_r;
  logic [1:0] gap_r;
  logic       second_r, irq_r, trig_d_r;
  logic       tick;

  // ==========================================
  // address decode, each alias one register
  wire s_c0 = addr == csas_pkg::ADDR_CTRL0 || addr == csas_pkg::ADDR_A_CTRL0;
  wire s_c1 = addr == csas_pkg::ADDR_CTRL1 || addr == csas_pkg::ADDR_A_CTRL1;
  wire s_c2 = addr == csas_pkg::ADDR_CTRL2 || addr == csas_pkg::ADDR_A_CTRL2;
  wire s_r0l = addr == csas_pkg::ADDR_R0L || addr == csas_pkg::ADDR_A_R0L;
  wire s_r0h = addr == csas_pkg::ADDR_R0H || addr == csas_pkg::ADDR_A_R0H;
  wire s_c3  = addr == csas_pkg::ADDR_CTRL3;
  wire s_st  = addr == csas_pkg::ADDR_STAT;
  wire s_pre = addr == csas_pkg::ADDR_PRE;
  wire s_acq = addr == csas_pkg::ADDR_ACQ;
  wire s_grd = addr == csas_pkg::ADDR_GRD;
  wire s_cap = addr == csas_pkg::ADDR_CAP;
  wire s_r1l = addr == csas_pkg::ADDR_R1L;
  wire s_r1h = addr == csas_pkg::ADDR_R1H;
  wire s_irq = addr == csas_pkg::ADDR_IRQ;

  // ==========================================
  // effective controls
  wire        on      = ctrl0_r[csas_pkg::CTRL0_ON];
  wire        busy    = ctrl0_r[csas_pkg::CTRL0_GO];
  wire [4:0]  chs     = ctrl0_r[6:2];
  wire        dsen    = ctrl3_r[csas_pkg::CTRL3_DSEN];
  wire        inv     = second_r && dsen && ctrl3_r[csas_pkg::CTRL3_IPEN];
  wire        ipol    = ctrl3_r[csas_pkg::CTRL3_IPPOL] ^ inv;
  wire        epol    = ctrl3_r[csas_pkg::CTRL3_EPPOL] ^ inv;
  wire        gpol    = grd_r[csas_pkg::GRD_POL] ^ inv;
  wire        trig_en = ctrl2_r[6:4] == csas_pkg::TRIG_TIMER;
  wire        trig_ev = on && trig_en && timer_trigger && !trig_d_r;
  wire        sw_go   = wr && s_c0 && wdata[csas_pkg::CTRL0_GO] && on;
  wire        start   = st_r == csas_pkg::CSAS_IDLE && (busy || trig_ev);
  wire        in_pre  = st_r == csas_pkg::CSAS_PRE;
  wire        in_acq  = st_r == csas_pkg::CSAS_ACQ;
  wire        in_conv = st_r == csas_pkg::CSAS_CONV;
  wire        conv_end = in_conv && tick && bits_r == 5'(csas_pkg::RES_BITS) - 5'h01;
  wire        abort   = !on || (wr && s_c0 && !wdata[csas_pkg::CTRL0_GO]);
  wire        finish  = st_r == csas_pkg::CSAS_DONE;
  wire [9:0]  shift_n = {shift_r[8:0], conv_bit};
  wire [9:0]  res_now = 10'(shift_r << (4'(csas_pkg::RES_BITS) - bits_r[3:0]));
  wire        pre_zero = pre_r[6:0] == 7'h00;

  // ==========================================
  // sequencer
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      csas_pkg::CSAS_IDLE: if (start) st_nxt = pre_zero ? csas_pkg::CSAS_ACQ
                                                        : csas_pkg::CSAS_PRE;
      csas_pkg::CSAS_PRE:  if (cnt_r == 7'h01) st_nxt = csas_pkg::CSAS_ACQ;
      csas_pkg::CSAS_ACQ:  if (cnt_r <= 7'h01) st_nxt = csas_pkg::CSAS_CONV;
      csas_pkg::CSAS_CONV: if (conv_end) st_nxt = csas_pkg::CSAS_DONE;
      csas_pkg::CSAS_DONE: st_nxt = (dsen && !second_r) ? csas_pkg::CSAS_GAP
                                                        : csas_pkg::CSAS_IDLE;
      csas_pkg::CSAS_GAP:  if (gap_r == 2'h1) st_nxt = pre_zero ? csas_pkg::CSAS_ACQ
                                                                : csas_pkg::CSAS_PRE;
      default: st_nxt = csas_pkg::CSAS_IDLE;
    endcase
    if (abort && st_r != csas_pkg::CSAS_IDLE) st_nxt = csas_pkg::CSAS_IDLE;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= csas_pkg::CSAS_IDLE;
      cnt_r <= 7'h00;
      gap_r <= 2'h0;
      bits_r <= 5'h00;
      shift_r <= 10'h000;
      second_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (st_nxt == csas_pkg::CSAS_PRE && !in_pre) cnt_r <= pre_r[6:0];
      else if (st_nxt == csas_pkg::CSAS_ACQ && !in_acq) cnt_r <= acq_r[6:0];
      else if (cnt_r != 7'h00) cnt_r <= cnt_r - 7'h01;
      gap_r <= finish ? csas_pkg::DOUBLE_GAP - 2'h1 : 2'h0;
      if (st_nxt == csas_pkg::CSAS_CONV && !in_conv) bits_r <= 5'h00;
      else if (in_conv && tick) bits_r <= bits_r + 5'h01;
      if (in_conv && tick) shift_r <= shift_n;
      if (start) second_r <= 1'b0;
      else if (finish) second_r <= 1'b1;
    end
  end

  // ==========================================
  // register writes and hardware updates
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl0_r <= csas_pkg::RST_BYTE;
      ctrl1_r <= csas_pkg::RST_BYTE;
      ctrl2_r <= csas_pkg::RST_BYTE;
      ctrl3_r <= csas_pkg::RST_BYTE;
      pre_r <= csas_pkg::RST_BYTE;
      acq_r <= csas_pkg::RST_BYTE;
      grd_r <= csas_pkg::RST_BYTE;
      cap_r <= csas_pkg::RST_BYTE;
      res0_r <= 10'h000;
      res1_r <= 10'h000;
      irq_r <= 1'b0;
      trig_d_r <= 1'b0;
    end else begin
      trig_d_r <= timer_trigger;
      if (wr && s_c0) ctrl0_r <= (wdata & csas_pkg::MASK_CTRL0) &
                                 {6'h3f, sw_go || busy && wdata[1], 1'b1};
      if (trig_ev && !busy) ctrl0_r[csas_pkg::CTRL0_GO] <= 1'b1;
      if (!on) ctrl0_r[csas_pkg::CTRL0_GO] <= 1'b0;
      if (finish && !(dsen && !second_r)) ctrl0_r[csas_pkg::CTRL0_GO] <= 1'b0;
      if (wr && s_c1) ctrl1_r <= wdata & csas_pkg::MASK_CTRL1;
      if (wr && s_c2) ctrl2_r <= wdata & csas_pkg::MASK_CTRL2;
      if (wr && s_c3) ctrl3_r <= wdata & csas_pkg::MASK_CTRL3;
      if (wr && s_pre) pre_r <= wdata & csas_pkg::MASK_COUNT;
      if (wr && s_acq) acq_r <= wdata & csas_pkg::MASK_COUNT;
      if (wr && s_grd) grd_r <= wdata & csas_pkg::MASK_GRD;
      if (wr && s_cap) cap_r <= wdata & csas_pkg::MASK_CAP;
      if (finish && !second_r) res0_r <= shift_r;
      if (finish && second_r) res1_r <= shift_r;
      if (in_conv && abort && !second_r) res0_r <= res_now;
      if (in_conv && abort && second_r) res1_r <= res_now;
      if (wr && s_irq && !wdata[0]) irq_r <= 1'b0;
      if (finish) irq_r <= 1'b1;
    end
  end

  // ==========================================
  // read data, result justification
  wire        fm = ctrl1_r[csas_pkg::CTRL1_FM];
  wire [7:0]  r0l = fm ? res0_r[7:0] : {res0_r[1:0], 6'h00};
  wire [7:0]  r0h = fm ? {6'h00, res0_r[9:8]} : res0_r[9:2];
  wire [7:0]  r1l = fm ? res1_r[7:0] : {res1_r[1:0], 6'h00};
  wire [7:0]  r1h = fm ? {6'h00, res1_r[9:8]} : res1_r[9:2];
  wire [7:0]  stat = {5'h00, in_conv, in_acq || in_pre, in_acq};
  wire [7:0]  rd_mux = s_c0 ? {1'b0, ctrl0_r[6:0]} :
                       s_c1 ? ctrl1_r : s_c2 ? ctrl2_r : s_c3 ? ctrl3_r :
                       s_st ? stat : s_pre ? pre_r : s_acq ? acq_r :
                       s_grd ? grd_r : s_cap ? cap_r : s_r0l ? r0l :
                       s_r0h ? r0h : s_r1l ? r1l : s_r1h ? r1h :
                       s_irq ? {7'h00, irq_r} : 8'h00;

  // ==========================================
  // channel decode
  logic [7:0] chan_nxt;
  always_comb begin
    chan_nxt = 8'h00;
    if (chs <= csas_pkg::CHS_IN_LAST) chan_nxt = 8'(8'h01 << chs[2:0]);
    else if (chs == csas_pkg::CHS_VREFP) chan_nxt = 8'h20;
    else if (chs == csas_pkg::CHS_TEMP) chan_nxt = 8'h40;
    else if (chs == csas_pkg::CHS_FIXREF) chan_nxt = 8'h80;
  end

  csas_clkdiv u_div (
    .clk  (clk),
    .rst  (rst),
    .run  (in_conv),
    .sel  (ctrl1_r[6:4]),
    .tick (tick)
  );

  // ==========================================
  // registered outputs
  wire oen  = ctrl3_r[csas_pkg::CTRL3_OEN];
  wire ooen = ctrl3_r[csas_pkg::CTRL3_OOEN];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
      conv_sample <= 1'b0;
      converter_enable <= 1'b0;
      channel_onehot <= 8'h00;
      extra_cap_select <= 3'h0;
      extra_cap_connect <= 1'b0;
      hold_capacitor_connect <= 1'b0;
      hold_precharge_level <= 1'b0;
      hold_precharge_en <= 1'b0;
      chan_pin_out <= 1'b0;
      chan_pin_oe <= 1'b0;
      bus_pass_gate <= 1'b0;
      analog_bus_pin_out <= 1'b0;
      analog_bus_pin_oe <= 1'b0;
      guard_a <= 1'b0;
      guard_b <= 1'b0;
      conversion_irq_flag <= 1'b0;
    end else begin
      rdata <= rd ? rd_mux : 8'h00;
      conv_sample <= in_conv && tick;
      converter_enable <= on;
      channel_onehot <= (on && !in_pre) ? chan_nxt : 8'h00;
      extra_cap_select <= cap_r[2:0];
      extra_cap_connect <= on && cap_r[2:0] != 3'h0 && !in_conv;
      hold_capacitor_connect <= on && in_acq;
      hold_precharge_level <= ipol;
      hold_precharge_en <= on && in_pre;
      chan_pin_out <= epol;
      chan_pin_oe <= on && in_pre;
      bus_pass_gate <= oen;
      analog_bus_pin_out <= ipol;
      analog_bus_pin_oe <= oen && ooen && on && in_pre;
      guard_a <= grd_r[csas_pkg::GRD_AOE] && on && (in_acq ? !gpol : gpol);
      guard_b <= grd_r[csas_pkg::GRD_BOE] && on && (in_acq ? gpol : !gpol);
      conversion_irq_flag <= irq_r;
    end
  end

  // ==========================================
  // assertions
  sequence s_finish_single;
    finish && !dsen;
  endsequence

  property p_go_clears;
    @(posedge clk) disable iff (rst) s_finish_single |=> !ctrl0_r[1];
  endproperty
  a_go_clears: assert property (p_go_clears) else $error("start bit not cleared");

  property p_flag_set;
    @(posedge clk) disable iff (rst) finish |=> irq_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_pin_override;
    @(posedge clk) disable iff (rst) analog_bus_pin_oe |-> $past(in_pre) && $past(oen);
  endproperty
  a_pin_override: assert property (p_pin_override) else $error("pin override out of stage");

  property p_bit7;
    @(posedge clk) disable iff (rst) rd && s_c0 |=> !rdata[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("control 0 bit 7 set");

  property p_cap_conv;
    @(posedge clk) disable iff (rst) in_conv ##1 in_conv |-> !extra_cap_connect;
  endproperty
  a_cap_conv: assert property (p_cap_conv) else $error("extra cap in conversion");

  property p_gap;
    @(posedge clk) disable iff (rst)
      finish && dsen && !second_r && on |=> st_r == csas_pkg::CSAS_GAP
        ##1 st_r != csas_pkg::CSAS_IDLE;
  endproperty
  a_gap: assert property (p_gap) else $error("second conversion not started");

  property p_pre_skip;
    @(posedge clk) disable iff (rst) start && pre_zero && !abort |=> in_acq;
  endproperty
  a_pre_skip: assert property (p_pre_skip) else $error("pre-charge not skipped");

  property p_off;
    @(posedge clk) disable iff (rst) !on |=> !ctrl0_r[1] && st_r == csas_pkg::CSAS_IDLE;
  endproperty
  a_off: assert property (p_off) else $error("disabled converter busy");

  sequence s_conv_tail;
    in_conv ##1 finish;
  endsequence

  property p_conv_bits;
    @(posedge clk) disable iff (rst) s_conv_tail |-> bits_r == 5'(csas_pkg::RES_BITS);
  endproperty
  a_conv_bits: assert property (p_conv_bits) else $error("result bit count wrong");

  property p_acq_pins;
    @(posedge clk) disable iff (rst)
      hold_capacitor_connect |-> !chan_pin_oe && !analog_bus_pin_oe;
  endproperty
  a_acq_pins: assert property (p_acq_pins) else $error("pin driven in acquisition");

  property p_override_pol;
    @(posedge clk) disable iff (rst)
      analog_bus_pin_oe |-> analog_bus_pin_out == hold_precharge_level;
  endproperty
  a_override_pol: assert property (p_override_pol) else $error("override level wrong");

  property p_trig_start;
    @(posedge clk) disable iff (rst) trig_ev && st_r == csas_pkg::CSAS_IDLE |=> busy;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger did not start");
endmodule : csas_top
`default_nettype wire

// ---- tb/cap_sense_adc_sequencer_test.sv ----
// self-checking bench for the sensing converter sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", what, e, g); end end
module cap_sense_adc_sequencer_test;
  logic        clk, rst, wr, rd, timer_trigger, conv_bit, conv_sample, converter_enable;
  logic [11:0] addr;
  logic [7:0]  wdata, rdata, channel_onehot, v;
  logic [2:0]  extra_cap_select;
  logic        extra_cap_connect, hold_capacitor_connect, hold_precharge_level;
  logic        hold_precharge_en, chan_pin_out, chan_pin_oe, bus_pass_gate;
  logic        analog_bus_pin_out, analog_bus_pin_oe, guard_a, guard_b;
  logic        conversion_irq_flag, exp_pol;
  int          failures, comparisons, oe_cnt, acq_cnt, smp_cnt, bad, pre_cnt, ep_cnt, ga_cnt;
  logic [7:0]  masks [6] = '{8'hdb, 8'h00, 8'h7f, 8'h7f, 8'hd0, 8'h07};
  logic [4:0]  codes [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
                              5'h19, 5'h1a, 5'h1b, 5'h1d, 5'h1e, 5'h1f};
  logic [7:0]  hots [12] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h00,
                             8'h00, 8'h20, 8'h00, 8'h40, 8'h00, 8'h80};

  csas_top csas_top_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .timer_trigger(timer_trigger), .conv_bit(conv_bit),
    .conv_sample(conv_sample), .converter_enable(converter_enable),
    .channel_onehot(channel_onehot), .extra_cap_select(extra_cap_select),
    .extra_cap_connect(extra_cap_connect), .hold_capacitor_connect(hold_capacitor_connect),
    .hold_precharge_level(hold_precharge_level), .hold_precharge_en(hold_precharge_en),
    .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe), .bus_pass_gate(bus_pass_gate),
    .analog_bus_pin_out(analog_bus_pin_out), .analog_bus_pin_oe(analog_bus_pin_oe),
    .guard_a(guard_a), .guard_b(guard_b), .conversion_irq_flag(conversion_irq_flag));

  csas_sensor_model csas_sensor_model_inst (.clk(clk), .rst(rst), .conv_sample(conv_sample),
    .hold_capacitor_connect(hold_capacitor_connect), .conv_bit(conv_bit),
    .hold_precharge_level(hold_precharge_level), .hold_precharge_en(hold_precharge_en));

  // ==========================================
  // clock, watchdog and pin monitor
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #1000000;
    failures++;
    wrap_up();
  end

  always @(posedge clk) begin
    if (analog_bus_pin_oe === 1'b1) begin
      oe_cnt++;
      if (analog_bus_pin_out !== exp_pol) bad++;
    end
    if (hold_capacitor_connect === 1'b1) begin
      acq_cnt++;
      if (guard_a === 1'b1) ga_cnt++;
      if (guard_a === guard_b || analog_bus_pin_oe !== 1'b0 || chan_pin_oe !== 1'b0) bad++;
    end
    if (chan_pin_oe === 1'b1) begin
      pre_cnt++;
      if (chan_pin_out === 1'b1) ep_cnt++;
    end
    if (conv_sample === 1'b1) begin
      smp_cnt++;
      if (extra_cap_connect !== 1'b0) bad++;
    end
  end

  // ==========================================
  // register access tasks
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    `CHK($sformatf("read %h", a), e, d)
  endtask : rd_chk

  task automatic clr_cnt();
    oe_cnt  = 0;
    acq_cnt = 0;
    smp_cnt = 0;
    bad     = 0;
    pre_cnt = 0;
    ep_cnt  = 0;
    ga_cnt  = 0;
  endtask : clr_cnt

  task automatic wait_done();
    for (int i = 0; i < 1000; i++) begin
      rd_reg(12'h711, v);
      if (v[1] === 1'b0) break;
    end
    `CHK("start bit", 1'b0, v[1])
  endtask : wait_done

  task automatic wrap_up();
    if (failures == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // ==========================================
  // test sequence
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 12'h000;
    wdata = 8'h00;
    timer_trigger = 1'b0;
    exp_pol = 1'b0;
    failures = 0;
    comparisons = 0;
    clr_cnt();
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // reset values and bank aliasing
    rd_chk(12'h711, 8'h00);
    rd_chk(12'h09d, 8'h00);
    wr_reg(12'h711, 8'hfd);
    rd_chk(12'h09d, 8'h7d);
    wr_reg(12'h09e, 8'hff);
    rd_chk(12'h712, 8'hf3);
    wr_reg(12'h713, 8'hff);
    rd_chk(12'h09f, 8'h70);
    rd_chk(12'h09a, 8'h00);
    rd_chk(12'h0a0, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr_reg(12'h714 + 12'(i), 8'hff);
      rd_chk(12'h714 + 12'(i), masks[i]);
    end
    repeat (3) @(posedge clk);
    `CHK("cap select", 3'h7, extra_cap_select)
    `CHK("cap connect", 1'b1, extra_cap_connect)
    // channel routing table
    for (int i = 0; i < 12; i++) begin
      wr_reg(12'h711, {1'b0, codes[i], 2'b01});
      repeat (3) @(posedge clk);
      `CHK("channel", hots[i], channel_onehot)
    end
    `CHK("enable", 1'b1, converter_enable)
    wr_reg(12'h711, 8'h00);
    repeat (3) @(posedge clk);
    `CHK("enable", 1'b0, converter_enable)
    `CHK("channel", 8'h00, channel_onehot)
    // single conversion, right justified, bus pin override
    wr_reg(12'h712, 8'h90);
    wr_reg(12'h713, 8'h00);
    wr_reg(12'h714, 8'h58);
    wr_reg(12'h716, 8'h05);
    wr_reg(12'h717, 8'h04);
    wr_reg(12'h719, 8'h03);
    wr_reg(12'h711, 8'h01);
    repeat (3) @(posedge clk);
    `CHK("pass gate", 1'b1, bus_pass_gate)
    exp_pol = 1'b1;
    clr_cnt();
    wr_reg(12'h711, 8'h03);
    wait_done();
    `CHK("override cycles", 5, oe_cnt)
    `CHK("acquire cycles", 4, acq_cnt)
    `CHK("bit samples", 10, smp_cnt)
    `CHK("pin faults", 0, bad)
    `CHK("pre-charge cycles", 5, pre_cnt)
    `CHK("channel drive level", 0, ep_cnt)
    `CHK("guard a in acquire", 0, ga_cnt)
    `CHK("irq flag", 1'b1, conversion_irq_flag)
    rd_chk(12'h71a, 8'h5a);
    rd_chk(12'h71b, 8'h01);
    rd_chk(12'h09b, 8'h5a);
    rd_chk(12'h09c, 8'h01);
    wr_reg(12'h720, 8'h00);
    repeat (3) @(posedge clk);
    `CHK("irq flag", 1'b0, conversion_irq_flag)
    // double conversion by trigger, inverted polarity, left justified
    wr_reg(12'h712, 8'h10);
    wr_reg(12'h713, 8'h30);
    wr_reg(12'h714, 8'h4b);
    clr_cnt();
    @(posedge clk);
    timer_trigger <= 1'b1;
    repeat (4) @(posedge clk);
    timer_trigger <= 1'b0;
    wait_done();
    `CHK("override cycles", 0, oe_cnt)
    `CHK("acquire cycles", 8, acq_cnt)
    `CHK("bit samples", 20, smp_cnt)
    `CHK("pre-charge cycles", 10, pre_cnt)
    `CHK("channel drive level", 5, ep_cnt)
    `CHK("guard a in acquire", 4, ga_cnt)
    `CHK("pin faults", 0, bad)
    rd_chk(12'h71a, 8'h80);
    rd_chk(12'h71b, 8'h56);
    rd_chk(12'h71c, 8'h40);
    rd_chk(12'h71d, 8'ha9);
    rd_chk(12'h714, 8'h4b);
    // pre-charge skipped, fastest conversion clock
    wr_reg(12'h712, 8'h00);
    wr_reg(12'h714, 8'h00);
    wr_reg(12'h716, 8'h00);
    clr_cnt();
    wr_reg(12'h711, 8'h03);
    wait_done();
    `CHK("pre-charge cycles", 0, pre_cnt)
    `CHK("acquire cycles", 4, acq_cnt)
    `CHK("bit samples", 10, smp_cnt)
    `CHK("pin faults", 0, bad)
    rd_chk(12'h71b, 8'ha9);
    // reset with the converter on and idle after the run returns control 0 to zero
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(12'h711, 8'h00);
    `CHK("enable", 1'b0, converter_enable)
    wrap_up();
  end
endmodule : cap_sense_adc_sequencer_test
`default_nettype wire

// ---- tb/csas_sensor_model.sv ----
// sensing electrode and comparator model feeding the converter bit stream
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// electrode charge level picks the word shifted out
module csas_sensor_model #(
  parameter logic [9:0] LVL_LOW  = 10'h2a5,
  parameter logic [9:0] LVL_HIGH = 10'h15a
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // converter side
  input  wire logic conv_sample,
  input  wire logic hold_capacitor_connect,
  input  wire logic hold_precharge_level,
  input  wire logic hold_precharge_en,
  // comparator bit
  output logic      conv_bit
);
  logic [3:0] idx_r;
  logic       lvl_r;
  logic [9:0] word;

  assign word     = lvl_r ? LVL_HIGH : LVL_LOW;
  assign conv_bit = word[4'h9 - idx_r];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_r <= 4'h0;
      lvl_r <= 1'b0;
    end else begin
      if (hold_precharge_en) lvl_r <= hold_precharge_level;
      if (hold_capacitor_connect) idx_r <= 4'h0;
      else if (conv_sample) idx_r <= (idx_r == 4'h9) ? 4'h0 : idx_r + 4'h1;
    end
  end
endmodule : csas_sensor_model
`default_nettype wire
